/* rtl/cmd_src_pkg.sv */
// Constants and types shared by the command source selector.
package cmd_src_pkg;

    // ---------------------------------------------------------------
    // Setting values
    // ---------------------------------------------------------------
    localparam logic [15:0] START_SRC_RESET = 16'h0000;
    localparam logic [15:0] SPEED_SRC_RESET = 16'h0000;
    localparam logic [15:0] PU_SRC_RESET    = 16'h270f;
    localparam logic [15:0] SRC_COMM        = 16'h0000;
    localparam logic [15:0] SRC_EXT         = 16'h0001;
    localparam logic [15:0] SPEED_EXT_PREF  = 16'h0002;
    localparam logic [15:0] PU_SRC_CONN     = 16'h0002;
    localparam logic [15:0] PU_SRC_PANEL    = 16'h0004;
    localparam logic [15:0] PU_SRC_AUTO     = 16'h270f;
    localparam logic [15:0] WP_ALL_WRITE    = 16'h0002;
    localparam logic [15:0] STARTUP_FOLLOW  = 16'h0000;
    localparam logic [15:0] STARTUP_NET     = 16'h0001;
    localparam logic [15:0] STARTUP_NET_SW  = 16'h000a;

    // ---------------------------------------------------------------
    // Operation modes (one-hot)
    // ---------------------------------------------------------------
    typedef enum logic [4:0] {
        MODE_PU    = 5'h01,
        MODE_EXT   = 5'h02,
        MODE_COMB3 = 5'h04,
        MODE_COMB4 = 5'h08,
        MODE_NET   = 5'h10
    } opMode_t;

    // Active authority holder, one-hot.
    typedef enum logic [3:0] {
        HOLD_PANEL = 4'h1,
        HOLD_UNIT  = 4'h2,
        HOLD_CONN  = 4'h4,
        HOLD_OTHER = 4'h8
    } holder_t;

endpackage : cmd_src_pkg

/* rtl/command_source_selector.sv */
// Command source selector for a motor drive.
`timescale 1ns/1ps
`default_nettype none
module command_source_selector (
    input  wire logic              mclk,
    input  wire logic              arst_n,
    input  wire logic [15:0]       startSourceSelect,
    input  wire logic [15:0]       speedSourceSelect,
    input  wire logic [15:0]       puModeSourceSelect,
    input  wire logic [15:0]       writeProtectSelect,
    input  wire logic [15:0]       startupModeSelect,
    input  wire cmd_src_pkg::opMode_t modeSetting,
    input  wire logic              unitAttached,
    input  wire logic              modeSwitchReq,
    input  wire cmd_src_pkg::opMode_t modeSwitchTarget,
    input  wire logic              commStartReq,
    input  wire logic              commStopReq,
    input  wire logic              commSpeedReq,
    input  wire logic              commWriteReq,
    input  wire logic              commWriteAlways,
    input  wire logic              commClearReq,
    input  wire logic              commResetReq,
    input  wire logic              commReadReq,
    input  wire logic              commModbus,
    input  wire logic              commError,
    input  wire logic              panelStop,
    input  wire logic              termStartReq,
    input  wire logic              termResetReq,
    input  wire logic              termSpeedPresent,
    input  wire logic              termMultiSpeed,
    input  wire logic              termAnalog4,
    input  wire logic              currentInputSelect,
    output logic                   commStartOk,
    output logic                   commStopOk,
    output logic                   commSpeedOk,
    output logic                   commWriteOk,
    output logic                   commResetOk,
    output logic                   commReadOk,
    output logic                   commRefused,
    output logic                   termStartOk,
    output logic                   termSpeedOk,
    output logic                   termResetOk,
    output logic                   useCommSpeed,
    output logic                   panelStopIndication,
    output logic                   modeLampsOn,
    output logic [4:0]             activeMode,
    output logic [3:0]             activeHolder,
    output logic [15:0]            latchedPuSource
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    // Settings are caught on the first clock after reset release, since
    // an asynchronous reset may only load constants.
    typedef struct packed {
        logic                 loaded;
        logic [15:0]          startSrc;
        logic [15:0]          speedSrc;
        logic [15:0]          puSrc;
        cmd_src_pkg::opMode_t mode;
        logic                 netSwap;
        logic                 errSeen;
        logic                 puStopped;
        logic                 cStartOk;
        logic                 cStopOk;
        logic                 cSpeedOk;
        logic                 cWriteOk;
        logic                 cResetOk;
        logic                 cReadOk;
        logic                 cRefused;
        logic                 tStartOk;
        logic                 tSpeedOk;
        logic                 tResetOk;
        logic                 useComm;
        logic                 stopInd;
        logic                 lamps;
        cmd_src_pkg::holder_t holder;
    } state_t;

    state_t stateQ;
    state_t stateD;

    logic srcConn;
    logic inPu;
    logic inNet;
    logic inExtComb;
    logic netStartComm;
    logic netSpeedComm;

    always_comb begin
        stateD = stateQ;
        srcConn = (stateQ.puSrc == cmd_src_pkg::PU_SRC_CONN);
        inPu = (stateQ.mode == cmd_src_pkg::MODE_PU);
        inNet = (stateQ.mode == cmd_src_pkg::MODE_NET);
        inExtComb = (stateQ.mode == cmd_src_pkg::MODE_EXT)
                  || (stateQ.mode == cmd_src_pkg::MODE_COMB3)
                  || (stateQ.mode == cmd_src_pkg::MODE_COMB4);
        netStartComm = (stateQ.startSrc == cmd_src_pkg::SRC_COMM);
        netSpeedComm = (stateQ.speedSrc == cmd_src_pkg::SRC_COMM)
                    || ((stateQ.speedSrc == cmd_src_pkg::SPEED_EXT_PREF)
                        && !termSpeedPresent);

        if (!stateQ.loaded) begin
            stateD.loaded   = 1'b1;
            stateD.startSrc = startSourceSelect;
            stateD.speedSrc = speedSourceSelect;
            stateD.puSrc    = puModeSourceSelect;
            stateD.netSwap  = (startupModeSelect == cmd_src_pkg::STARTUP_NET_SW);
            if ((startupModeSelect == cmd_src_pkg::STARTUP_NET
                 || startupModeSelect == cmd_src_pkg::STARTUP_NET_SW)
                && (modeSetting != cmd_src_pkg::MODE_PU)
                && (modeSetting != cmd_src_pkg::MODE_COMB3)
                && (modeSetting != cmd_src_pkg::MODE_COMB4)
                && (puModeSourceSelect != cmd_src_pkg::PU_SRC_CONN)) begin
                stateD.mode = cmd_src_pkg::MODE_NET;
            end else begin
                stateD.mode = modeSetting;
            end
        end else begin
            if (modeSwitchReq) begin
                if (!(srcConn && modeSwitchTarget == cmd_src_pkg::MODE_NET)) begin
                    stateD.mode = modeSwitchTarget;
                end
            end
        end

        // A later error clear is not modelled: the flag holds until reset.
        if (commError) begin
            stateD.errSeen = 1'b1;
        end
        if (panelStop) begin
            stateD.puStopped = 1'b1;
        end else if (termStartReq || commStartReq) begin
            stateD.puStopped = 1'b0;
        end

        case (stateQ.mode)
            cmd_src_pkg::MODE_PU: begin
                if (srcConn) begin
                    stateD.holder = cmd_src_pkg::HOLD_CONN;
                end else if (stateQ.puSrc == cmd_src_pkg::PU_SRC_AUTO && unitAttached) begin
                    stateD.holder = cmd_src_pkg::HOLD_UNIT;
                end else begin
                    stateD.holder = cmd_src_pkg::HOLD_PANEL;
                end
            end
            cmd_src_pkg::MODE_EXT,
            cmd_src_pkg::MODE_COMB3,
            cmd_src_pkg::MODE_COMB4,
            cmd_src_pkg::MODE_NET: begin
                stateD.holder = cmd_src_pkg::HOLD_OTHER;
            end
            default: begin
                stateD.holder = cmd_src_pkg::HOLD_OTHER;
            end
        endcase
        stateD.lamps = (stateD.holder == cmd_src_pkg::HOLD_PANEL);

        stateD.cStartOk = commStartReq && !(commModbus && inPu) && (srcConn
            ? (inPu || stateQ.mode == cmd_src_pkg::MODE_COMB4)
            : (inNet && netStartComm));
        stateD.cStopOk = commStopReq && !(commModbus && inPu) && (srcConn
            ? (inPu || stateQ.mode == cmd_src_pkg::MODE_COMB4
               || (inExtComb && stateQ.puStopped))
            : (inNet && netStartComm));
        stateD.cSpeedOk = commSpeedReq && !(commModbus && inPu) && (srcConn
            ? (inPu || stateQ.mode == cmd_src_pkg::MODE_COMB3)
            : (inNet && netSpeedComm));
        stateD.cWriteOk = commWriteReq && !commClearReq && !(commModbus && inPu)
            && ((srcConn ? !inNet && stateQ.mode != cmd_src_pkg::MODE_EXT : inNet)
                || commWriteAlways
                || writeProtectSelect == cmd_src_pkg::WP_ALL_WRITE);
        stateD.cResetOk = commResetReq && !stateQ.errSeen && !(commModbus && inPu)
            && (srcConn ? !inNet : inNet);
        stateD.cReadOk = commReadReq;
        stateD.cRefused = (commStartReq && !stateD.cStartOk)
            || (commStopReq && !stateD.cStopOk)
            || (commSpeedReq && !stateD.cSpeedOk)
            || (commWriteReq && !stateD.cWriteOk)
            || (commResetReq && !stateD.cResetOk);
        stateD.tStartOk = termStartReq && ((stateQ.mode == cmd_src_pkg::MODE_EXT)
            || (stateQ.mode == cmd_src_pkg::MODE_COMB3)
            || (inNet && !netStartComm));
        stateD.tSpeedOk = termSpeedPresent && ((stateQ.mode == cmd_src_pkg::MODE_EXT)
            || (stateQ.mode == cmd_src_pkg::MODE_COMB4)
            || (stateQ.mode == cmd_src_pkg::MODE_COMB3
                && (termMultiSpeed || (termAnalog4 && currentInputSelect)))
            || (inNet && !netSpeedComm));
        stateD.tResetOk = termResetReq;
        stateD.useComm = inNet && netSpeedComm;
        stateD.stopInd = stateQ.puStopped && inExtComb;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stateQ <= '{loaded: 1'b0,
                        startSrc: cmd_src_pkg::START_SRC_RESET,
                        speedSrc: cmd_src_pkg::SPEED_SRC_RESET,
                        puSrc: cmd_src_pkg::PU_SRC_RESET,
                        mode: cmd_src_pkg::MODE_EXT,
                        holder: cmd_src_pkg::HOLD_OTHER,
                        default: 1'b0};
        end else begin
            stateQ <= stateD;
        end
    end

    assign commStartOk         = stateQ.cStartOk;
    assign commStopOk          = stateQ.cStopOk;
    assign commSpeedOk         = stateQ.cSpeedOk;
    assign commWriteOk         = stateQ.cWriteOk;
    assign commResetOk         = stateQ.cResetOk;
    assign commReadOk          = stateQ.cReadOk;
    assign commRefused         = stateQ.cRefused;
    assign termStartOk         = stateQ.tStartOk;
    assign termSpeedOk         = stateQ.tSpeedOk;
    assign termResetOk         = stateQ.tResetOk;
    assign useCommSpeed        = stateQ.useComm;
    assign panelStopIndication = stateQ.stopInd;
    assign modeLampsOn         = stateQ.lamps;
    assign activeMode          = stateQ.mode;
    assign activeHolder        = stateQ.holder;
    assign latchedPuSource     = stateQ.puSrc;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    AST_NO_NET_WITH_CONN: assert property (
        stateQ.loaded && srcConn |=> stateQ.mode != cmd_src_pkg::MODE_NET)
        else $error("network mode entered with connector source");
    AST_SETTINGS_HELD: assert property (
        stateQ.loaded |=> $stable(stateQ.puSrc) && $stable(stateQ.startSrc))
        else $error("source settings changed without reset");
    // Judged from the mode and the setting, not from the holder that drives the lamps.
    AST_LAMPS_OFF: assert property (
        !inPu || srcConn |=> !modeLampsOn)
        else $error("mode lamps lit without panel authority");
    AST_READ_ALWAYS: assert property (
        commReadReq |=> commReadOk)
        else $error("read request not accepted");
    AST_CLEAR_REFUSED: assert property (
        commClearReq |=> !commWriteOk)
        else $error("parameter clear accepted");
    AST_RESET_AFTER_ERR: assert property (
        stateQ.errSeen && commResetReq |=> !commResetOk && commRefused)
        else $error("host reset accepted after error");
    AST_MODBUS_PU: assert property (
        commModbus && inPu |=> !commStartOk && !commWriteOk && !commSpeedOk)
        else $error("modbus request served in local panel mode");
    AST_TERM_RESET: assert property (
        termResetReq |=> termResetOk)
        else $error("terminal reset refused");
    AST_NONCONN_START: assert property (
        !srcConn && !inNet && commStartReq |=> !commStartOk && commRefused)
        else $error("serial start accepted outside network mode");

endmodule : command_source_selector
`default_nettype wire

/* tb/command_source_selector_tb.sv */
// Self-checking testbench for the command source selector.
`timescale 1ns/1ps
`default_nettype none
module command_source_selector_tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic mclk = 1'b0, arst_n = 1'b0, unitAttached = 1'b0, modeSwitchReq = 1'b0;
    logic [15:0] startSourceSelect = 16'h0000, speedSourceSelect = 16'h0000;
    logic [15:0] puModeSourceSelect = 16'h270f, writeProtectSelect = 16'h0000;
    logic [15:0] startupModeSelect = 16'h0000, latchedPuSource;
    cmd_src_pkg::opMode_t modeSetting = cmd_src_pkg::MODE_EXT;
    cmd_src_pkg::opMode_t modeSwitchTarget = cmd_src_pkg::MODE_NET;
    logic commWriteAlways = 1'b0, panelStop = 1'b0, termStartReq = 1'b0, termResetReq = 1'b0;
    logic termSpeedPresent = 1'b0, termAnalog4 = 1'b0, currentInputSelect = 1'b0, modbus;
    logic termMultiSpeed = 1'b0;
    logic commStartOk, commStopOk, commSpeedOk, commWriteOk, commResetOk, commReadOk;
    logic commRefused, termStartOk, termSpeedOk, termResetOk, useCommSpeed;
    logic panelStopIndication, modeLampsOn;
    logic [7:0] reqs;
    logic [4:0] activeMode;
    logic [3:0] activeHolder;
    int badCount = 0, checks = 0;
    localparam int START = 0, STOP = 1, SPEED = 2, WRITE = 3, RST = 4, READ = 5, CLEAR = 6;

    command_source_selector command_source_selector_inst (
        .mclk, .arst_n, .startSourceSelect, .speedSourceSelect, .puModeSourceSelect,
        .writeProtectSelect, .startupModeSelect, .modeSetting, .unitAttached, .modeSwitchReq,
        .modeSwitchTarget, .commStartReq(reqs[0]), .commStopReq(reqs[1]), .commSpeedReq(reqs[2]),
        .commWriteReq(reqs[3]), .commWriteAlways, .commClearReq(reqs[6]),
        .commResetReq(reqs[4]), .commReadReq(reqs[5]), .commModbus(modbus),
        .commError(reqs[7]), .panelStop, .termStartReq, .termResetReq, .termSpeedPresent,
        .termMultiSpeed, .termAnalog4, .currentInputSelect, .commStartOk, .commStopOk,
        .commSpeedOk, .commWriteOk, .commResetOk, .commReadOk, .commRefused, .termStartOk,
        .termSpeedOk, .termResetOk, .useCommSpeed, .panelStopIndication, .modeLampsOn,
        .activeMode, .activeHolder, .latchedPuSource
    );
    serial_host_model serial_host_model_inst (.mclk, .reqs, .modbus);

    always #4 mclk = ~mclk;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            badCount++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : idle
    // Settings are only taken at reset, so every test starts with a fresh one.
    task automatic boot(input logic [15:0] st, sp, pu, input cmd_src_pkg::opMode_t md,
                        input logic [15:0] su);
        idle(1);
        arst_n = 1'b0;
        startSourceSelect = st;
        speedSourceSelect = sp;
        puModeSourceSelect = pu;
        modeSetting = md;
        startupModeSelect = su;
        idle(5);
        arst_n = 1'b1;
        idle(3);
    endtask : boot
    task automatic cmd(input int b, input logic mb, input logic expOk);
        logic [6:0] oks;
        serial_host_model_inst.send(b, mb);
        oks = {commWriteOk, commReadOk, commResetOk, commWriteOk, commSpeedOk, commStopOk,
               commStartOk};
        chk(oks[b], expOk, "serial verdict");
        chk(commRefused, !expOk, "serial refusal");
    endtask : cmd
    task automatic term(input logic isReset, input logic expOk);
        idle(1);
        termResetReq = isReset;
        termStartReq = !isReset;
        idle(1);
        termResetReq = 1'b0;
        termStartReq = 1'b0;
        chk(isReset ? termResetOk : termStartOk, expOk, "terminal verdict");
    endtask : term
    task automatic pulse(ref logic s);
        idle(1);
        s = 1'b1;
        idle(1);
        s = 1'b0;
        idle(1);
    endtask : pulse
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        #100000;
        badCount++;
        conclude();
    end
    initial begin
        boot(16'h0000, 16'h0000, 16'h270f, cmd_src_pkg::MODE_EXT, 16'h0001);
        chk(activeMode, cmd_src_pkg::MODE_NET, "power-on mode");
        chk(modeLampsOn, 1'b0, "lamps in network mode");
        chk(useCommSpeed, 1'b1, "speed origin");
        cmd(START, 1'b1, 1'b1);
        cmd(SPEED, 1'b0, 1'b1);
        cmd(WRITE, 1'b0, 1'b1);
        cmd(CLEAR, 1'b0, 1'b0);
        cmd(RST, 1'b0, 1'b1);
        cmd(READ, 1'b0, 1'b1);
        $display("test network defaults done");
        boot(16'h0001, 16'h0001, 16'h270f, cmd_src_pkg::MODE_EXT, 16'h0001);
        cmd(START, 1'b0, 1'b0);
        cmd(SPEED, 1'b0, 1'b0);
        term(1'b0, 1'b1);
        chk(useCommSpeed, 1'b0, "speed origin external");
        boot(16'h0000, 16'h0002, 16'h270f, cmd_src_pkg::MODE_EXT, 16'h000a);
        chk(useCommSpeed, 1'b1, "no terminal speed");
        termSpeedPresent = 1'b1;
        idle(2);
        chk(useCommSpeed, 1'b0, "terminal speed wins");
        termSpeedPresent = 1'b0;
        $display("test network sources done");
        boot(16'h0000, 16'h0000, 16'h0002, cmd_src_pkg::MODE_PU, 16'h0000);
        chk(activeHolder, cmd_src_pkg::HOLD_CONN, "connector holder");
        chk(modeLampsOn, 1'b0, "lamps with connector");
        cmd(START, 1'b0, 1'b1);
        cmd(SPEED, 1'b0, 1'b1);
        cmd(WRITE, 1'b0, 1'b1);
        cmd(RST, 1'b0, 1'b1);
        cmd(START, 1'b1, 1'b0);
        pulse(modeSwitchReq);
        chk(activeMode, cmd_src_pkg::MODE_PU, "network switch");
        serial_host_model_inst.send(7, 1'b0);
        cmd(RST, 1'b0, 0);
        $display("test connector source done");
        boot(16'h0000, 16'h0000, 16'h0004, cmd_src_pkg::MODE_PU, 16'h0000);
        chk(activeHolder, cmd_src_pkg::HOLD_PANEL, "panel holder");
        chk(modeLampsOn, 1'b1, "lamps with panel");
        cmd(START, 1'b0, 1'b0);
        term(1'b1, 1'b1);
        term(1'b0, 1'b0);
        pulse(modeSwitchReq);
        chk(activeMode, cmd_src_pkg::MODE_NET, "network switch allowed");
        chk(modeLampsOn, 1'b0, "lamps off in network mode");
        boot(16'h0000, 16'h0000, 16'h270f, cmd_src_pkg::MODE_PU, 16'h0000);
        chk(activeHolder, cmd_src_pkg::HOLD_PANEL, "auto panel");
        unitAttached = 1'b1;
        idle(2);
        chk(activeHolder, cmd_src_pkg::HOLD_UNIT, "auto unit");
        cmd(READ, 1'b0, 1'b1);
        chk(activeHolder, cmd_src_pkg::HOLD_UNIT, "traffic keeps holder");
        puModeSourceSelect = 16'h0002;
        unitAttached = 1'b0;
        idle(2);
        chk(latchedPuSource, 16'h270f, "setting held");
        chk(activeHolder, cmd_src_pkg::HOLD_PANEL, "old setting active");
        cmd(START, 1'b0, 1'b0);
        chk(activeHolder, cmd_src_pkg::HOLD_PANEL, "traffic leaves panel");
        boot(16'h0000, 16'h0000, 16'h0002, cmd_src_pkg::MODE_EXT, 16'h0000);
        chk(latchedPuSource, 16'h0002, "setting taken at reset");
        $display("test panel and unit done");
        cmd(START, 1'b0, 1'b0);
        cmd(STOP, 1'b0, 1'b0);
        pulse(panelStop);
        chk(panelStopIndication, 1'b1, "stop indication");
        cmd(STOP, 1'b0, 1'b1);
        cmd(WRITE, 1'b0, 1'b0);
        commWriteAlways = 1'b1;
        cmd(WRITE, 1'b0, 1'b1);
        commWriteAlways = 1'b0;
        writeProtectSelect = 16'h0002;
        cmd(WRITE, 1'b0, 1'b1);
        writeProtectSelect = 16'h0000;
        boot(16'h0000, 16'h0000, 16'h0002, cmd_src_pkg::MODE_COMB3, 16'h0000);
        cmd(SPEED, 1'b0, 1'b1);
        cmd(START, 1'b0, 1'b0);
        term(1'b0, 1'b1);
        termSpeedPresent = 1'b1;
        termAnalog4 = 1'b1;
        idle(2);
        chk(termSpeedOk, 1'b0, "terminal 4 without select");
        currentInputSelect = 1'b1;
        idle(2);
        chk(termSpeedOk, 1'b1, "terminal 4 with select");
        currentInputSelect = 1'b0;
        termMultiSpeed = 1'b1;
        idle(2);
        chk(termSpeedOk, 1'b1, "multi-speed input");
        termMultiSpeed = 1'b0;
        boot(16'h0000, 16'h0000, 16'h0002, cmd_src_pkg::MODE_COMB4, 16'h0000);
        cmd(START, 1'b0, 1'b1);
        cmd(SPEED, 1'b0, 1'b0);
        $display("test combined modes done");
        conclude();
    end
endmodule : command_source_selector_tb
`default_nettype wire

/* tb/serial_host_model.sv */
// Host computer model that issues serial requests to the selector.
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
    input  wire logic       mclk,
    output var  logic [7:0] reqs,
    output var  logic       modbus
);
    // ------------------------------------------------------------
    // Request issue
    // ------------------------------------------------------------
    initial begin
        reqs   = 8'h00;
        modbus = 1'b0;
    end
    // Bit 6 is a clear, which always travels as a write; bit 7 flags a link error.
    task automatic send(input int bitIdx, input logic mb);
        @(posedge mclk);
        #1;
        reqs[bitIdx] = 1'b1;
        if (bitIdx == 6) reqs[3] = 1'b1;
        modbus = mb;
        @(posedge mclk);
        #1;
        reqs   = 8'h00;
        modbus = 1'b0;
    endtask : send
endmodule : serial_host_model
`default_nettype wire
